// ==== hdl/event_signal_pkg.sv ====
// Package: register map, field layout and carrier types for the event signalling block
package event_signal_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W             = 12;
    localparam logic [11:0] EXP_FOUR_ADDR_OFS  = 12'h358;
    localparam logic [11:0] EVENT_CTRL_OFS     = 12'h35C;
    localparam logic [11:0] EVENT_STATUS_OFS   = 12'h360;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int          NUM_PORTS          = 4;
    localparam int          FIRST_PORT         = 2;
    localparam int          EXP_ADDR_LSB       = 1;
    localparam int          EXP_ADDR_W         = 7;
    localparam int          POLARITY_BIT       = 0;
    localparam int          DIVERT_LSB         = 2;
    localparam int          STATUS_LSB         = 1;

    // ------------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [6:0]  EXP_ADDR_RST       = 7'h00;
    localparam logic        POLARITY_RST       = 1'b0;
    localparam logic [3:0]  DIVERT_RST         = 4'h0;
    localparam logic        POL_ACTIVE_LOW     = 1'b0;
    localparam logic        POL_ACTIVE_HIGH    = 1'b1;

    // Control fields that steer the event logic
    typedef struct packed {
        logic       event_polarity_invert;
        logic [3:0] divert_enable;
    } event_ctrl_t;

    // Pin-facing bundle for general purpose I/O line 7
    typedef struct packed {
        logic level;
        logic oe;
    } pin_drive_t;

endpackage

// ==== hdl/event_combiner.sv ====
// Event combiner: per-port gating, status and shared pin level
`timescale 1ns/1ps

module event_combiner
    import event_signal_pkg::*;
#(
    parameter int PORTS = event_signal_pkg::NUM_PORTS
) (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // Control and events
    input  wire event_signal_pkg::event_ctrl_t ctrl_i,
    input  wire logic [PORTS-1:0]            port_event_i,
    input  wire logic                        alt_function_i,
    // Results
    output logic [PORTS-1:0]                 event_active_o,
    output event_signal_pkg::pin_drive_t     pin_o,
    output logic [PORTS-1:0]                 native_event_o
);

    // ------------------------------------------------------------------
    // Per-port gating
    // ------------------------------------------------------------------
    logic [PORTS-1:0] active_d;
    logic [PORTS-1:0] active_q;
    logic [PORTS-1:0] native_d;
    logic [PORTS-1:0] native_q;
    pin_drive_t       pin_d;
    pin_drive_t       pin_q;

    // Diverted ports raise status; others keep their native path
    for (genvar p = 0; p < PORTS; p++) begin : g_port
        always_comb begin
            active_d[p] = ctrl_i.divert_enable[p] & port_event_i[p];
            native_d[p] = ~ctrl_i.divert_enable[p] & port_event_i[p];
        end
    end

    // Pin level: OR first, then polarity; idle level is the deasserted one
    always_comb begin
        pin_d.level = (|active_d) ^ ~ctrl_i.event_polarity_invert;
        pin_d.oe    = alt_function_i;
    end

    // Registered so status and pin change on the same edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_q <= '0;
            native_q <= '0;
            pin_q    <= '{level: 1'b1, oe: 1'b0};
        end else begin
            active_q <= active_d;
            native_q <= native_d;
            pin_q    <= pin_d;
        end
    end

    assign event_active_o = active_q;
    assign native_event_o = native_q;
    assign pin_o          = pin_q;

endmodule

// ==== hdl/event_signaling.sv ====
// Top level: Wishbone register file for shared event pin and expander four address
`timescale 1ns/1ps

module event_signaling
    import event_signal_pkg::*;
#(
    parameter int PORTS = event_signal_pkg::NUM_PORTS
) (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // Wishbone slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [11:0]               wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic [31:0]                    wb_dat_o,
    output logic                           wb_ack_o,
    // Port events and native notification path
    input  wire logic [PORTS-1:0]          port_event_i,
    output logic [PORTS-1:0]               native_event_o,
    // General purpose I/O line 7
    input  wire logic                      gpio7_alt_function_i,
    output logic                           shared_event_output_o,
    output logic                           shared_event_output_oe_o,
    // Expander address toward the SMBus master
    output logic [6:0]                     expander_four_slave_address_o
);

    import event_signal_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [6:0]       exp_addr_d;
    logic [6:0]       exp_addr_q;
    event_ctrl_t      ctrl_d;
    event_ctrl_t      ctrl_q;
    logic             ack_d;
    logic             ack_q;
    logic [31:0]      rdata_d;
    logic [31:0]      rdata_q;
    logic             req;
    logic [PORTS-1:0] event_active;
    pin_drive_t       pin;

    // New request only when no ack is outstanding, so ack lasts one cycle
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;

    // Writes honour byte lane 0; all fields sit in the low byte
    always_comb begin
        exp_addr_d = exp_addr_q;
        ctrl_d     = ctrl_q;
        if (req && wb_we_i && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                EXP_FOUR_ADDR_OFS: begin
                    exp_addr_d = wb_dat_i[EXP_ADDR_LSB +: EXP_ADDR_W];
                end
                EVENT_CTRL_OFS: begin
                    ctrl_d.event_polarity_invert = wb_dat_i[POLARITY_BIT];
                    ctrl_d.divert_enable = wb_dat_i[DIVERT_LSB +: NUM_PORTS];
                end
                default: begin
                    exp_addr_d = exp_addr_q;
                end
            endcase
        end
    end

    // Read mux; unmapped addresses and reserved bits read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        ack_d   = req;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                EXP_FOUR_ADDR_OFS: begin
                    rdata_d[EXP_ADDR_LSB +: EXP_ADDR_W] = exp_addr_q;
                end
                EVENT_CTRL_OFS: begin
                    rdata_d[POLARITY_BIT] = ctrl_q.event_polarity_invert;
                    rdata_d[DIVERT_LSB +: NUM_PORTS] = ctrl_q.divert_enable;
                end
                EVENT_STATUS_OFS: begin
                    rdata_d[STATUS_LSB +: NUM_PORTS] = event_active;
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    // Register everything on the clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            exp_addr_q <= EXP_ADDR_RST;
            ctrl_q     <= '{event_polarity_invert: POLARITY_RST, divert_enable: DIVERT_RST};
            ack_q      <= 1'b0;
            rdata_q    <= 32'h0000_0000;
        end else begin
            exp_addr_q <= exp_addr_d;
            ctrl_q     <= ctrl_d;
            ack_q      <= ack_d;
            rdata_q    <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Event combining
    // ------------------------------------------------------------------
    event_combiner #(
        .PORTS (PORTS)
    ) u_combiner (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .ctrl_i         (ctrl_q),
        .port_event_i   (port_event_i),
        .alt_function_i (gpio7_alt_function_i),
        .event_active_o (event_active),
        .pin_o          (pin),
        .native_event_o (native_event_o)
    );

    assign wb_dat_o                      = rdata_q;
    assign wb_ack_o                      = ack_q;
    assign shared_event_output_o         = pin.level;
    assign shared_event_output_oe_o      = pin.oe;
    assign expander_four_slave_address_o = exp_addr_q;

endmodule

// ==== test/event_signaling_props.sv ====
// Checker for the event signalling top level
`timescale 1ns/1ps
// ----
// Shadow registers and assertions
// ----
module event_signaling_props #(parameter int PORTS = 4) (
    input wire logic             clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic [11:0]      wb_adr_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic [31:0]      wb_dat_i, wb_dat_o,
    input wire logic [PORTS-1:0] port_event_i, native_event_o,
    input wire logic             gpio7_alt_function_i, shared_event_output_o,
    input wire logic             shared_event_output_oe_o,
    input wire logic [6:0]       expander_four_slave_address_o
);
    logic [3:0]       div_q;
    logic             pol_q;
    logic             pin_q;
    logic [6:0]       adr_q;
    logic [PORTS-1:0] nat_q;
    wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    wire rd = wb_ack_o & ~wb_we_i;
    // Mirror of the control fields, taken from the bus itself
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 4'h0;
            pol_q <= 1'b0;
            adr_q <= 7'h00;
            nat_q <= '0;
            pin_q <= 1'b1;
        end else begin
            if (wr && wb_adr_i == 12'h35C) {div_q, pol_q} <= {wb_dat_i[5:2], wb_dat_i[0]};
            if (wr && wb_adr_i == 12'h358) adr_q <= wb_dat_i[7:1];
            pin_q <= (|(div_q & port_event_i)) ^ ~pol_q;
            nat_q <= port_event_i & ~div_q;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    AST_PIN: assert property (shared_event_output_o == pin_q)
        else $error("pin level wrong");
    AST_NATIVE: assert property (native_event_o == nat_q)
        else $error("native path wrong");
    AST_OE: assert property (!$past(rst_i) |->
        shared_event_output_oe_o == $past(gpio7_alt_function_i)) else $error("oe wrong");
    AST_ADDR_OUT: assert property (expander_four_slave_address_o == adr_q)
        else $error("address out wrong");
    AST_ADDR_RD: assert property (rd && wb_adr_i == 12'h358 |->
        wb_dat_o == {24'h0, adr_q, 1'b0}) else $error("address read wrong");
    AST_CTRL_RD: assert property (rd && wb_adr_i == 12'h35C |->
        wb_dat_o == {26'h0, div_q, 1'b0, pol_q}) else $error("control read wrong");
    AST_STS_RD: assert property (rd && wb_adr_i == 12'h360 |->
        wb_dat_o[31:5] == 0 && !wb_dat_o[0] && !(wb_dat_o[4:1] & ~div_q))
        else $error("status read wrong");
endmodule
bind event_signaling event_signaling_props #(.PORTS(PORTS)) u_props (.*);

// ==== test/event_pin_watcher.sv ====
// Model of the system logic that watches the shared event line
`timescale 1ns/1ps
module event_pin_watcher (
    input  wire logic level_i, oe_i, active_high_i,
    output logic      line_o, event_seen_o
);
    // Board pull-up holds the line high while the switch leaves it undriven
    assign line_o       = oe_i ? level_i : 1'b1;
    assign event_seen_o = line_o == active_high_i;
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the event signalling block
`timescale 1ns/1ps
module tb;
    import event_signal_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, alt = 0, pol = 0;
    logic        ack, pin, oe, line, seen;
    logic [11:0] adr = '0;
    logic [3:0]  sel = '0, ev = '0, nat, m;
    logic [31:0] wdat = '0, rdat, d, r;
    logic [6:0]  xadr;
    logic [31:0] expq[$];
    int          err_total = 0, num_checks = 0;
    always #5 clk_i = ~clk_i;
    event_signaling u_event_signaling (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .port_event_i(ev), .native_event_o(nat),
        .gpio7_alt_function_i(alt), .shared_event_output_o(pin),
        .shared_event_output_oe_o(oe), .expander_four_slave_address_o(xadr));
    event_pin_watcher u_event_pin_watcher (.level_i(pin), .oe_i(oe), .active_high_i(pol),
        .line_o(line), .event_seen_o(seen));
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // One classic cycle; reads leave their expected word for the monitor
    task automatic bus(logic w, logic [11:0] a, logic [31:0] v, logic [3:0] s, logic [31:0] e);
        if (!w) expq.push_back(e);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, v, s};
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        {cyc, stb, we} <= 3'b000;
        @(posedge clk_i);
    endtask
    // Read results are compared in arrival order
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) begin
            d = expq.pop_front();
            chk("read data", d, rdat);
        end
    end
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk_i);
        err_total++;
        summarize();
    end
    initial begin
        void'($urandom(32'h36B32848));
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        bus(0, EXP_FOUR_ADDR_OFS, 0, 4'hF, 0);
        bus(0, EVENT_CTRL_OFS, 0, 4'hF, 0);
        bus(0, EVENT_STATUS_OFS, 0, 4'hF, 0);
        r = $urandom();
        bus(1, EXP_FOUR_ADDR_OFS, r, 4'hF, 0);
        bus(1, EXP_FOUR_ADDR_OFS, ~r, 4'hE, 0); // Low byte lane off: no change
        bus(0, EXP_FOUR_ADDR_OFS, 0, 4'hF, {24'h0, r[7:1], 1'b0});
        chk("expander address", {25'h0, r[7:1]}, {25'h0, xadr});
        // Mid-run reset: address clears, pin returns to its idle level
        rst_i <= 1;
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        chk("reset address", 0, {25'h0, xadr});
        chk("reset pin", 1, 32'(pin));
        chk("reset oe", 0, 32'(oe));
        bus(0, EXP_FOUR_ADDR_OFS, 0, 4'hF, 0);
        bus(1, EVENT_STATUS_OFS, 32'hFFFFFFFF, 4'hF, 0);
        bus(1, 12'h400, 32'hFFFFFFFF, 4'hF, 0);
        bus(0, 12'h400, 0, 4'hF, 0);
        bus(0, EVENT_STATUS_OFS, 0, 4'hF, 0);
        alt <= 1;
        // Each port alone, then all four at once, in both polarities
        for (int p = 0; p < 16; p++) begin
            m = p[2] ? 4'hF : 4'h1 << p[1:0];
            r = $urandom() | (32'h1 << p[1:0]);
            pol <= p[3];
            bus(1, EVENT_CTRL_OFS, {26'h0, m, 1'b0, p[3]}, 4'hF, 0);
            ev <= r[3:0];
            repeat (3) @(posedge clk_i);
            bus(0, EVENT_CTRL_OFS, 0, 4'hF, {26'h0, m, 1'b0, p[3]});
            bus(0, EVENT_STATUS_OFS, 0, 4'hF, {27'h0, r[3:0] & m, 1'b0});
            chk("pin asserted", 32'(p[3]), 32'(pin));
            chk("native", {28'h0, r[3:0] & ~m}, {28'h0, nat});
            chk("event seen", 1, 32'(seen));
            ev <= r[3:0] & ~m;
            repeat (3) @(posedge clk_i);
            chk("pin idle", 32'(!p[3]), 32'(pin));
            bus(0, EVENT_STATUS_OFS, 0, 4'hF, 0);
        end
        alt <= 0;
        repeat (3) @(posedge clk_i);
        chk("oe", 0, 32'(oe));
        chk("line", 1, 32'(line));
        summarize();
    end
endmodule
